// ---- rtl/srae_map.svh ----
// Offsets, codes and counts of the serial read address engine
`ifndef SRAE_MAP_SVH
`define SRAE_MAP_SVH
`define SRAE_ADDR_W 16
`define SRAE_ADDR_RESET 16'h0000
`define SRAE_ARRAY_CODE 7'h57
`define SRAE_TKREG_CODE 7'h6F
`define SRAE_ARRAY_ADDR_W 15
`define SRAE_TKREG_ADDR_W 8
`endif

// ---- rtl/srae_pkg.sv ----
// Types of the serial read address engine
package srae_pkg;
   typedef enum logic [6:0] {
      SRAE_IDLE  = 7'b0000001,
      SRAE_SLAVE = 7'b0000010,
      SRAE_SACK  = 7'b0000100,
      SRAE_WADDR = 7'b0001000,
      SRAE_WACK  = 7'b0010000,
      SRAE_SEND  = 7'b0100000,
      SRAE_MACK  = 7'b1000000
   } srae_state_e;
endpackage : srae_pkg

// ---- rtl/srae_mem_if.sv ----
// Memory read port carried between the engine and its storage
`timescale 1ns/1ps
interface srae_mem_if;
   logic rd_en;
   logic sect;
   logic [15:0] addr;
   logic [7:0] data;
   modport eng (output rd_en, output sect, output addr, input data);
   modport mem (input rd_en, input sect, input addr, output data);
endinterface : srae_mem_if

// ---- rtl/srae_mem.sv ----
// Storage for the array and the timekeeping register section, registered read
`timescale 1ns/1ps
module srae_mem
   import srae_pkg::*;
#(
   parameter int ARRAY_W = 15,
   parameter int TKREG_W = 8
) (
   input wire logic clock,
   input wire logic wr_en,
   input wire logic wr_sect,
   input wire logic [15:0] wr_addr,
   input wire logic [7:0] wr_data,
   srae_mem_if.mem port
);
   logic [7:0] array_mem [0:(1<<ARRAY_W)-1];
   logic [7:0] tkreg_mem [0:(1<<TKREG_W)-1];

   // Load port for contents and registered read port
   always_ff @(posedge clock) begin
      if (wr_en && !wr_sect) begin
         array_mem[wr_addr[ARRAY_W-1:0]] <= wr_data;
      end
      if (wr_en && wr_sect) begin
         tkreg_mem[wr_addr[TKREG_W-1:0]] <= wr_data;
      end
      if (port.rd_en) begin
         port.data <= port.sect ? tkreg_mem[port.addr[TKREG_W-1:0]] : array_mem[port.addr[ARRAY_W-1:0]];
      end
   end
endmodule : srae_mem

// ---- rtl/srae_engine.sv ----
// Read side of a two-wire slave: address counter and read sequencing
`timescale 1ns/1ps
`include "srae_map.svh"
// How it works
// - Counter holds last address read plus one.
// - Counter clears to zero at reset.
// - Matching read slave byte is acknowledged, then eight data bits go out.
// - After address bytes, repeated start and read byte return data.
// - Stop after address bytes loads the counter.
// - After that stop, bus is ignored until a new start.
// - Each master acknowledge sends the next byte.
// - Counter crosses page and column boundaries freely.
// - Past the last address the counter wraps to zero.
// - First byte of a sequential read is as a single read.
// - Only the array or timekeeping code is acknowledged.
// - No acknowledge from the master stops sending and releases data.
module srae_engine
   import srae_pkg::*;
#(
   parameter int ADDR_W = `SRAE_ADDR_W
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   output logic [ADDR_W-1:0] read_addr,
   output logic tkreg_sel,
   output logic busy,
   input wire logic load_en,
   input wire logic load_sect,
   input wire logic [15:0] load_addr,
   input wire logic [7:0] load_data
);
   srae_mem_if mem_bus ();
   srae_state_e state, next_state;
   logic scl_q, sda_q, scl_d, sda_d;
   logic [3:0] bit_cnt, next_bit_cnt;
   logic [7:0] shreg, next_shreg;
   logic [ADDR_W-1:0] addr, next_addr;
   logic [ADDR_W-1:0] wptr, next_wptr;
   logic waddr_hi, next_waddr_hi;
   logic sect, next_sect;
   logic next_sda_oe;
   logic mem_rd, next_mem_rd;
   logic start_c, stop_c, rise, fall;

   srae_mem #(.ARRAY_W(`SRAE_ARRAY_ADDR_W), .TKREG_W(`SRAE_TKREG_ADDR_W)) u_mem (
      .clock(clock),
      .wr_en(load_en),
      .wr_sect(load_sect),
      .wr_addr(load_addr),
      .wr_data(load_data),
      .port(mem_bus)
   );
   assign mem_bus.rd_en = mem_rd;
   assign mem_bus.sect = sect;
   assign mem_bus.addr = addr;

   // Bus edge and condition detection on delayed line copies
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         scl_q <= 1'b1;
         sda_q <= 1'b1;
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end else begin
         scl_q <= scl_in;
         sda_q <= sda_in;
         scl_d <= scl_q;
         sda_d <= sda_q;
      end
   end
   assign rise = scl_q && !scl_d;
   assign fall = !scl_q && scl_d;
   assign start_c = scl_q && scl_d && sda_d && !sda_q;
   assign stop_c = scl_q && scl_d && !sda_d && sda_q;

   // Next state of the read sequencer
   always_comb begin
      next_state = state;
      next_bit_cnt = bit_cnt;
      next_shreg = shreg;
      next_addr = addr;
      next_wptr = wptr;
      next_waddr_hi = waddr_hi;
      next_sect = sect;
      next_sda_oe = sda_oe;
      next_mem_rd = 1'b0;
      if (start_c) begin
         next_state = SRAE_SLAVE;
         next_bit_cnt = 4'h0;
         next_sda_oe = 1'b0;
      end else if (stop_c) begin
         if (state == SRAE_WADDR && bit_cnt == 4'h0 && !waddr_hi) begin
            next_addr = wptr;
         end
         next_state = SRAE_IDLE;
         next_sda_oe = 1'b0;
      end else begin
         unique case (state)
            SRAE_IDLE: begin
               next_sda_oe = 1'b0;
            end
            SRAE_SLAVE: begin
               if (rise) begin
                  next_shreg = {shreg[6:0], sda_q};
                  next_bit_cnt = bit_cnt + 4'h1;
               end
               if (fall && bit_cnt == 4'h8) begin
                  if (shreg[7:1] == `SRAE_ARRAY_CODE || shreg[7:1] == `SRAE_TKREG_CODE) begin
                     next_sect = (shreg[7:1] == `SRAE_TKREG_CODE);
                     next_sda_oe = 1'b1;
                     next_state = SRAE_SACK;
                     next_mem_rd = shreg[0];
                  end else begin
                     next_state = SRAE_IDLE;
                  end
               end
            end
            SRAE_SACK: begin
               if (fall) begin
                  next_bit_cnt = 4'h0;
                  if (shreg[0]) begin
                     next_shreg = mem_bus.data;
                     next_addr = ADDR_W'(addr + 1'b1);
                     next_sda_oe = !mem_bus.data[7];
                     next_state = SRAE_SEND;
                  end else begin
                     next_sda_oe = 1'b0;
                     next_waddr_hi = 1'b1;
                     next_state = SRAE_WADDR;
                  end
               end
            end
            SRAE_WADDR: begin
               if (rise) begin
                  next_shreg = {shreg[6:0], sda_q};
                  next_bit_cnt = bit_cnt + 4'h1;
               end
               if (fall && bit_cnt == 4'h8) begin
                  if (waddr_hi) begin
                     next_wptr = {shreg, wptr[7:0]};
                  end else begin
                     next_wptr = {wptr[15:8], shreg};
                  end
                  next_sda_oe = 1'b1;
                  next_state = SRAE_WACK;
               end
            end
            SRAE_WACK: begin
               if (fall) begin
                  next_sda_oe = 1'b0;
                  next_bit_cnt = 4'h0;
                  next_waddr_hi = 1'b0;
                  next_state = waddr_hi ? SRAE_WADDR : SRAE_IDLE;
                  if (!waddr_hi) begin
                     next_addr = wptr;
                     next_state = SRAE_WADDR;
                  end
               end
            end
            SRAE_SEND: begin
               if (fall) begin
                  if (bit_cnt == 4'h7) begin
                     next_sda_oe = 1'b0;
                     next_state = SRAE_MACK;
                     next_mem_rd = 1'b1;
                  end else begin
                     next_shreg = {shreg[6:0], 1'b1};
                     next_sda_oe = !shreg[6];
                     next_bit_cnt = bit_cnt + 4'h1;
                  end
               end
            end
            SRAE_MACK: begin
               if (rise && sda_q) begin
                  next_state = SRAE_IDLE;
               end else if (fall) begin
                  next_shreg = mem_bus.data;
                  next_addr = ADDR_W'(addr + 1'b1);
                  next_bit_cnt = 4'h0;
                  next_sda_oe = !mem_bus.data[7];
                  next_state = SRAE_SEND;
               end
            end
         endcase
      end
   end

   // Sequencer registers
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         state <= SRAE_IDLE;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         addr <= `SRAE_ADDR_RESET;
         wptr <= `SRAE_ADDR_RESET;
         waddr_hi <= 1'b0;
         sect <= 1'b0;
         sda_oe <= 1'b0;
         mem_rd <= 1'b0;
         read_addr <= `SRAE_ADDR_RESET;
         tkreg_sel <= 1'b0;
         busy <= 1'b0;
      end else begin
         state <= next_state;
         bit_cnt <= next_bit_cnt;
         shreg <= next_shreg;
         addr <= next_addr;
         wptr <= next_wptr;
         waddr_hi <= next_waddr_hi;
         sect <= next_sect;
         sda_oe <= next_sda_oe;
         mem_rd <= next_mem_rd;
         read_addr <= next_addr;
         tkreg_sel <= next_sect;
         busy <= (next_state != SRAE_IDLE);
      end
   end
   assign sda_out = 1'b0; // Open drain: only ever pulls low

   // Checks
   property p_reset_addr;
      @(posedge clock) $fell(rst) |-> read_addr == `SRAE_ADDR_RESET;
   endproperty
   a_reset_addr: assert property (p_reset_addr) else $error("address not zero after reset");
   property p_inc;
      @(posedge clock) disable iff (rst)
         (state == SRAE_MACK && next_state == SRAE_SEND) |=> addr == $past(addr) + 16'h0001;
   endproperty
   a_inc: assert property (p_inc) else $error("counter did not advance by one");
   property p_wrap;
      @(posedge clock) disable iff (rst)
         (state == SRAE_MACK && next_state == SRAE_SEND && addr == 16'hFFFF) |=> addr == 16'h0000;
   endproperty
   a_wrap: assert property (p_wrap) else $error("counter did not wrap");
   property p_nack_release;
      @(posedge clock) disable iff (rst)
         (state == SRAE_MACK && rise && sda_q && !start_c && !stop_c) |=> !sda_oe && state == SRAE_IDLE;
   endproperty
   a_nack_release: assert property (p_nack_release) else $error("line held after no acknowledge");
   property p_idle_quiet;
      @(posedge clock) disable iff (rst) state == SRAE_IDLE |=> !sda_oe;
   endproperty
   a_idle_quiet: assert property (p_idle_quiet) else $error("drive while idle");
   property p_bad_code;
      @(posedge clock) disable iff (rst)
         (state == SRAE_SLAVE && fall && bit_cnt == 4'h8 && !start_c && !stop_c
          && shreg[7:1] != `SRAE_ARRAY_CODE && shreg[7:1] != `SRAE_TKREG_CODE) |=> !sda_oe;
   endproperty
   a_bad_code: assert property (p_bad_code) else $error("foreign code acknowledged");
   property p_ack_read;
      @(posedge clock) disable iff (rst)
         (state == SRAE_SLAVE && next_state == SRAE_SACK) |=> sda_oe;
   endproperty
   a_ack_read: assert property (p_ack_read) else $error("matching byte not acknowledged");
   property p_preload;
      @(posedge clock) disable iff (rst)
         (stop_c && state == SRAE_WADDR && bit_cnt == 4'h0 && !waddr_hi) |=> addr == $past(wptr);
   endproperty
   a_preload: assert property (p_preload) else $error("preload not taken");
   c_read: cover property (@(posedge clock) state == SRAE_SACK && shreg[0]);
   c_seq: cover property (@(posedge clock) state == SRAE_MACK ##1 state == SRAE_SEND);
   c_preload: cover property (@(posedge clock) stop_c && state == SRAE_WADDR && !waddr_hi);
endmodule : srae_engine

// ---- verification/srae_master.sv ----
// Two-wire bus master model that clocks the link and runs read transfers
`timescale 1ns/1ps
module srae_master (
   input wire logic clock,
   input wire logic line,
   output logic scl,
   output logic sda
);
   // Bus idles with both lines released high
   initial begin
      scl = 1'h1;
      sda = 1'h1;
   end
   task automatic hold(input int n);
      repeat (n) @(negedge clock);
   endtask : hold
   // One bit slot: data set in the low phase, line sampled mid-high
   task automatic bit_x(input logic b, output logic r);
      hold(3);
      sda = b;
      hold(3);
      scl = 1'h1;
      hold(3);
      r = line;
      hold(3);
      scl = 1'h0;
   endtask : bit_x
   // Start, or repeated start when SCL is low
   task automatic start();
      hold(3);
      sda = 1'h1;
      hold(3);
      scl = 1'h1;
      hold(6);
      sda = 1'h0;
      hold(6);
      scl = 1'h0;
   endtask : start
   // Stop from SCL low
   task automatic stop();
      hold(3);
      sda = 1'h0;
      hold(3);
      scl = 1'h1;
      hold(6);
      sda = 1'h1;
      hold(6);
   endtask : stop
   // Byte out with the slave's acknowledge read back
   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(d[i], r);
      end
      bit_x(1'h1, r);
      ack = ~r;
   endtask : wr_byte
   // Byte in; acknowledge asks for more, high through the ninth clock ends it
   task automatic rd_byte(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_x(1'h1, d[i]);
      end
      bit_x(~more, r);
   endtask : rd_byte
endmodule : srae_master

// ---- verification/srae_tb.sv ----
// Self-checking bench for the serial read address engine
`timescale 1ns/1ps
`include "srae_map.svh"
module testbench;
   import srae_pkg::*;
   localparam int LIMIT = 20000;
   localparam logic [7:0] AW = {`SRAE_ARRAY_CODE, 1'h0};
   localparam logic [7:0] AR = {`SRAE_ARRAY_CODE, 1'h1};
   localparam logic [7:0] TW = {`SRAE_TKREG_CODE, 1'h0};
   localparam logic [7:0] TR = {`SRAE_TKREG_CODE, 1'h1};
   logic clock = 1'h0;
   logic rst = 1'h1;
   logic load_en = 1'h0;
   logic load_sect = 1'h0;
   logic [15:0] load_addr = 16'h0000;
   logic [7:0] load_data = 8'h00;
   logic scl, m_sda, sda_out, sda_oe, tkreg_sel, busy;
   logic [15:0] read_addr;
   int fail_count = 0;
   int samples_checked = 0;
   int cycles = 0;
   // Pulled-up data line, low when either party pulls it
   wire logic sda_line = m_sda & ~(sda_oe & ~sda_out);
   always #2 clock = ~clock;
   srae_engine uut (.clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe(sda_oe), .read_addr(read_addr), .tkreg_sel(tkreg_sel), .busy(busy), .load_en(load_en),
      .load_sect(load_sect), .load_addr(load_addr), .load_data(load_data));
   srae_master master (.clock(clock), .line(sda_line), .scl(scl), .sda(m_sda));
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : end_sim
   // Hang guard
   always @(posedge clock) begin
      cycles++;
      if (cycles == LIMIT) begin
         fail_count++;
         end_sim();
      end
   end
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   function automatic logic [7:0] exp_byte(input logic s, input logic [15:0] a);
      return s ? (8'hC3 ^ a[7:0]) : (8'h5A ^ a[7:0] ^ a[14:7]);
   endfunction : exp_byte
   task automatic put(input logic s, input logic [15:0] a);
      load_en = 1'h1;
      load_sect = s;
      load_addr = a;
      load_data = exp_byte(s, a);
      @(negedge clock);
   endtask : put
   // Dummy write of a word address, left open for a stop or repeated start
   task automatic set_addr(input logic [7:0] sb, input logic [15:0] a);
      logic ack;
      master.start();
      master.wr_byte(sb, ack);
      check("slave ack", {15'h0000, ack}, 16'h0001);
      master.wr_byte(a[15:8], ack);
      check("high addr ack", {15'h0000, ack}, 16'h0001);
      master.wr_byte(a[7:0], ack);
      check("low addr ack", {15'h0000, ack}, 16'h0001);
      check("busy in transfer", {15'h0000, busy}, 16'h0001);
   endtask : set_addr
   // Read n bytes from a, acknowledging all but the last
   task automatic rd_run(input logic [7:0] sb, input logic s, input logic [15:0] a, input int n);
      logic ack;
      logic [7:0] d;
      master.start();
      master.wr_byte(sb, ack);
      check("read ack", {15'h0000, ack}, 16'h0001);
      for (int k = 0; k < n; k++) begin
         master.rd_byte(k < n - 1, d);
         check("data", {8'h00, d}, {8'h00, exp_byte(s, a + 16'(k))});
      end
      master.hold(4);
      check("released", {15'h0000, sda_oe}, 16'h0000);
      check("idle after end", {15'h0000, busy}, 16'h0000);
      check("open drain level", {15'h0000, sda_out}, 16'h0000);
      master.stop();
   endtask : rd_run
   task automatic t_power_up();
      check("reset addr", read_addr, 16'h0000);
      rd_run(AR, 1'h0, 16'h0000, 2);
      check("next addr", read_addr, 16'h0002);
      $display("test power_up done");
   endtask : t_power_up
   task automatic t_bad_code();
      logic ack;
      master.start();
      master.wr_byte(8'hAB, ack);
      check("foreign code ack", {15'h0000, ack}, 16'h0000);
      check("idle after foreign code", {15'h0000, busy}, 16'h0000);
      master.stop();
      $display("test bad_code done");
   endtask : t_bad_code
   task automatic t_preload();
      logic ack;
      set_addr(AW, 16'h007E);
      master.stop();
      master.wr_byte(AR, ack);
      check("ack without start", {15'h0000, ack}, 16'h0000);
      master.stop();
      check("preloaded", read_addr, 16'h007E);
      rd_run(AR, 1'h0, 16'h007E, 3);
      check("after run", read_addr, 16'h0081);
      $display("test preload done");
   endtask : t_preload
   task automatic t_wrap();
      set_addr(AW, 16'hFFFE);
      rd_run(AR, 1'h0, 16'hFFFE, 3);
      check("wrapped", read_addr, 16'h0001);
      $display("test wrap done");
   endtask : t_wrap
   task automatic t_tkreg();
      set_addr(TW, 16'h0005);
      rd_run(TR, 1'h1, 16'h0005, 2);
      check("section", {15'h0000, tkreg_sel}, 16'h0001);
      $display("test tkreg done");
   endtask : t_tkreg
   // Reset with the bus idle after a stop: counter back to zero, next current read starts at the first location
   task automatic t_reset();
      rst = 1'h1;
      master.hold(16);
      rst = 1'h0;
      master.hold(2);
      check("addr after reset", read_addr, 16'h0000);
      check("idle after reset", {15'h0000, busy}, 16'h0000);
      rd_run(AR, 1'h0, 16'h0000, 1);
      check("addr after single read", read_addr, 16'h0001);
      $display("test reset done");
   endtask : t_reset
   // Main sequence
   initial begin
      repeat (16) @(negedge clock);
      rst = 1'h0;
      for (int a = 0; a < 2; a++) begin
         put(1'h0, 16'(a));
      end
      for (int a = 16'h007E; a < 16'h0081; a++) begin
         put(1'h0, 16'(a));
      end
      put(1'h0, 16'hFFFE);
      put(1'h0, 16'hFFFF);
      put(1'h1, 16'h0005);
      put(1'h1, 16'h0006);
      load_en = 1'h0;
      t_power_up();
      t_bad_code();
      t_preload();
      t_wrap();
      t_tkreg();
      t_reset();
      end_sim();
   end
endmodule : testbench
